// File: src/acdc_pkg.sv
// acdc_pkg: shared constants and carriers for the audio channel dma control block
// assumes: one 25 MHz clock domain, registers reached by controller-register commands
package acdc_pkg;

  // controller register indices
  localparam logic [7:0] ADDR_LEGACY_IRQ = 8'hB1;
  localparam logic [7:0] ADDR_DRQ_CTRL = 8'hB2;
  localparam logic [7:0] ADDR_IN_VOL = 8'hB4;
  localparam logic [7:0] ADDR_HOLD_LO = 8'hB5;
  localparam logic [7:0] ADDR_HOLD_HI = 8'hB6;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'hB7;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'hB8;
  localparam logic [7:0] ADDR_XFER_TYPE = 8'hB9;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hA4;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hA5;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_IN_VOL = 8'hFF;
  localparam logic [7:0] RST_RELOAD_LO = 8'h00;
  localparam logic [7:0] RST_RELOAD_HI = 8'hF8;
  localparam logic [7:0] RST_CTRL_ONE = 8'h10;

  // legacy interrupt control fields
  localparam int LI_COMPAT = 7;
  localparam int LI_MASK_DONE = 6;
  localparam int LI_MASK_HALF = 5;
  localparam int LI_MASK_ALL = 4;
  localparam logic [7:0] LI_WMASK = 8'hFC;

  // dma request control fields
  localparam int DQ_COMPAT = 7;
  localparam int DQ_EXT_EN = 6;
  localparam int DQ_CMP_EN = 5;
  localparam int DQ_PULLDN = 4;
  localparam int DQ_SEL_HI = 3;
  localparam int DQ_SEL_LO = 2;
  localparam logic [7:0] DQ_WMASK = 8'hFC;

  // control one fields
  localparam int C1_LINK = 7;
  localparam int C1_SIGNED = 5;
  localparam int C1_STEREO = 3;
  localparam int C1_WIDE = 2;
  localparam int C1_LOAD = 0;

  // control two fields
  localparam int C2_DAC = 3;
  localparam int C2_AUTO = 2;
  localparam int C2_READ = 1;
  localparam int C2_RUN_N = 0;
  localparam logic [7:0] C2_WMASK = 8'h0F;
  localparam logic [7:0] TT_WMASK = 8'h03;

  localparam logic [15:0] CNT_LAST = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] PAIR_NONE = 2'h0;

  typedef enum logic [1:0] {
    ACDC_IDLE,
    ACDC_RUN,
    ACDC_HALT
  } acdc_state_e;

  // register access from the command engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acdc_req_s;

  // format and direction seen by the fifo and codec
  typedef struct packed {
    logic link;
    logic signed_fmt;
    logic stereo;
    logic wide;
    logic dac_mode;
    logic auto_init;
    logic read_dir;
    logic [3:0] vol_left;
    logic [3:0] vol_right;
  } acdc_cfg_s;

  // per-pair request pin drive
  typedef struct packed {
    logic [2:0] drq_o;
    logic [2:0] drq_oe;
  } acdc_pins_s;

  typedef struct packed {
    logic [7:0] li;
    logic [7:0] dq;
    logic [7:0] vol;
    logic [7:0] hold_lo;
    logic [7:0] hold_hi;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] tt;
    logic [15:0] reload;
    logic [15:0] count;
    acdc_state_e st;
    logic [15:0] dac;
    logic dac_load;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    logic srclk_q;
    logic [2:0] ack_s1;
    logic [2:0] ack_s2;
    logic [2:0] ack_s3;
    logic sr_s1;
    logic sr_s2;
  } acdc_state_s;

endpackage : acdc_pkg

// File: src/acdc_top.sv
// acdc_top: extended-mode control for the first audio channel, request pins and dac hold
// assumes: command engine gives one-cycle register strobes; pins and sample clock are async
`timescale 1ns/10ps

// Behaviour
// RULE_01 - legacy control bit 7 picks compatibility (1) or extended (0) interrupts.
// RULE_02 - legacy bit 6 set suppresses the extended transfer-complete interrupt.
// RULE_03 - legacy bit 5 set suppresses the fifo half-empty transition interrupt.
// RULE_04 - legacy bit 4 set masks every interrupt source of the channel.
// RULE_05 - legacy bits 3:2 only store a line code for readback.
// RULE_06 - any reset clears request control bits 7:5, disabling requests.
// RULE_07 - selected request is inactive when both enable bits 6:5 are low.
// RULE_08 - request bit 4 pulls the inactive request low, else it floats.
// RULE_09 - request bit 7 picks compatibility (1) or extended (0) request behaviour.
// RULE_10 - request bit 6 enables extended dma pins; clear means block i/o.
// RULE_11 - request bit 5 enables pins for compatibility dma transfers.
// RULE_12 - request bits 3:2 select none, pair a, pair b or pair c.
// RULE_13 - input volume holds left/right 4-bit gains, resets to FFh.
// RULE_14 - two byte registers form the 16-bit dac holding register.
// RULE_15 - control one bit 7 connects the fifo to the converter.
// RULE_16 - software keeps control one bit 6 inverse of bit 3.
// RULE_17 - control one bit 5 selects signed or offset-binary fifo data.
// RULE_18 - control one bit 3 selects stereo, bit 2 selects 16-bit samples.
// RULE_19 - control one bit 0 loads dac on next sample edge, then self-clears.
// RULE_20 - control two bit 3 picks dac mode, bit 2 auto-initialize.
// RULE_21 - control two bit 1 set makes the channel a dma read source.
// RULE_22 - control two bit 0 low holds the channel dma inactive.
// RULE_23 - 16-bit counter loads reload at start and overflow, counts each byte.
// RULE_24 - normal mode stops on overflow; auto mode continues, interrupting each overflow.
// RULE_25 - interrupt is or of unmasked events, forced low by the all-sources mask.
module acdc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire acdc_pkg::acdc_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // fifo side
  input wire logic fifo_want,
  input wire logic half_toggle,
  input wire logic sample_clk,
  output acdc_pkg::acdc_cfg_s cfg,
  output logic [15:0] dac_data,
  output logic dac_load,
  output logic block_io,
  output logic byte_taken,
  // dma pins
  input wire logic [2:0] dma_acknowledge_n,
  output acdc_pkg::acdc_pins_s pins,
  // interrupt
  output logic compat_irq_mode,
  output logic irq
);
  import acdc_pkg::*;

  acdc_state_s s_reg;
  acdc_state_s s_next;
  logic [1:0] sel;
  logic dma_on;
  logic ack_seen;
  logic overflow;
  logic sr_edge;
  logic half_q;

  // two-bit pair field to a one-hot pin vector; none gives zero
  function automatic logic [2:0] pair_hot(input logic [1:0] code);
    logic [2:0] v;
    v = 3'h0;
    if (code != PAIR_NONE) begin
      v[code - 2'h1] = 1'b1;
    end
    return v;
  endfunction : pair_hot

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the stored controls
  assign sel = s_reg.dq[DQ_SEL_HI:DQ_SEL_LO]; // RULE_12
  // both enable bits low forces the request inactive, run bit low holds it too
  assign dma_on = (s_reg.dq[DQ_EXT_EN] | s_reg.dq[DQ_CMP_EN]) // RULE_07
    & s_reg.c2[C2_RUN_N]; // RULE_22
  // block i/o when extended mode is selected without its dma enable
  assign block_io = ~s_reg.dq[DQ_COMPAT] & ~s_reg.dq[DQ_EXT_EN]; // RULE_09 RULE_10
  // acknowledge only counts on the selected pair, and only once synchronised
  assign ack_seen = |(pair_hot(sel) & ~s_reg.ack_s2 & s_reg.ack_s3) & dma_on; // RULE_11
  assign overflow = ack_seen & (s_reg.count == CNT_LAST);
  assign sr_edge = s_reg.sr_s2 & ~s_reg.srclk_q;
  assign half_q = half_toggle;

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.dac_load = 1'b0;
    // pins pass two flops; third stage only feeds the edge detector
    s_next.ack_s1 = dma_acknowledge_n;
    s_next.ack_s2 = s_reg.ack_s1;
    s_next.ack_s3 = s_reg.ack_s2;
    s_next.sr_s1 = sample_clk;
    s_next.sr_s2 = s_reg.sr_s1;
    s_next.srclk_q = s_reg.sr_s2;

    // register writes
    if (req.wr) begin
      case (req.addr)
        ADDR_LEGACY_IRQ: s_next.li = req.wdata & LI_WMASK; // RULE_05
        ADDR_DRQ_CTRL: s_next.dq = req.wdata & DQ_WMASK;
        ADDR_IN_VOL: s_next.vol = req.wdata; // RULE_13
        ADDR_HOLD_LO: s_next.hold_lo = req.wdata; // RULE_14
        ADDR_HOLD_HI: s_next.hold_hi = req.wdata; // RULE_14
        ADDR_CTRL_ONE: s_next.c1 = req.wdata;
        ADDR_CTRL_TWO: s_next.c2 = req.wdata & C2_WMASK;
        ADDR_XFER_TYPE: s_next.tt = req.wdata & TT_WMASK;
        ADDR_RELOAD_LO: s_next.reload[7:0] = req.wdata;
        ADDR_RELOAD_HI: s_next.reload[15:8] = req.wdata;
        default: s_next.tt = s_next.tt;
      endcase
    end

    // dac load waits for the sample edge; a fresh write of 1 re-arms the bit
    if (s_reg.c1[C1_LOAD] && sr_edge) begin
      s_next.dac = {s_reg.hold_hi, s_reg.hold_lo}; // RULE_19
      s_next.dac_load = 1'b1;
      if (!(req.wr && req.addr == ADDR_CTRL_ONE)) begin
        s_next.c1[C1_LOAD] = 1'b0; // RULE_19
      end
    end

    // register reads, one cycle later
    if (req.rd) begin
      s_next.rvalid = 1'b1;
      case (req.addr)
        ADDR_LEGACY_IRQ: s_next.rdata = s_reg.li;
        ADDR_DRQ_CTRL: s_next.rdata = s_reg.dq;
        ADDR_IN_VOL: s_next.rdata = s_reg.vol;
        ADDR_HOLD_LO: s_next.rdata = s_reg.hold_lo;
        ADDR_HOLD_HI: s_next.rdata = s_reg.hold_hi;
        ADDR_CTRL_ONE: s_next.rdata = s_reg.c1;
        ADDR_CTRL_TWO: s_next.rdata = s_reg.c2;
        ADDR_XFER_TYPE: s_next.rdata = s_reg.tt;
        ADDR_RELOAD_LO: s_next.rdata = s_reg.reload[7:0];
        ADDR_RELOAD_HI: s_next.rdata = s_reg.reload[15:8];
        default: s_next.rdata = RST_ZERO;
      endcase
    end

    // transfer sequencer
    s_next.irq = 1'b0;
    case (s_reg.st)
      ACDC_IDLE: begin
        if (dma_on) begin
          s_next.count = s_reg.reload; // RULE_23
          s_next.st = ACDC_RUN;
        end
      end
      ACDC_RUN: begin
        if (!dma_on) begin
          s_next.st = ACDC_IDLE;
        end else if (overflow) begin
          s_next.count = s_reg.reload; // RULE_23
          s_next.irq = 1'b1;
          // normal mode halts until software restarts via the run bit
          s_next.st = s_reg.c2[C2_AUTO] ? ACDC_RUN : ACDC_HALT; // RULE_24
        end else if (ack_seen) begin
          s_next.count = s_reg.count + CNT_ONE; // RULE_23
        end
      end
      ACDC_HALT: begin
        if (!dma_on) begin
          s_next.st = ACDC_IDLE;
        end
      end
      default: s_next.st = ACDC_IDLE;
    endcase
    // event masking: complete and half-empty each gated, then the global mask
    s_next.irq = ((s_next.irq & ~s_reg.li[LI_MASK_DONE]) // RULE_02
      | (half_q & ~s_reg.li[LI_MASK_HALF])) // RULE_03
      & ~s_reg.li[LI_MASK_ALL]; // RULE_04 RULE_25

    if (rst) begin
      s_next = '0;
      s_next.dq = RST_ZERO; // RULE_06
      s_next.vol = RST_IN_VOL; // RULE_13
      s_next.reload = {RST_RELOAD_HI, RST_RELOAD_LO};
      s_next.c1 = RST_CTRL_ONE;
      s_next.st = ACDC_IDLE;
      s_next.ack_s1 = 3'h7;
      s_next.ack_s2 = 3'h7;
      s_next.ack_s3 = 3'h7;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; synchronous reset folded into next state
  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  // request asserts only while running and the fifo asks; inactive low drive needs bit 4
  always_comb begin
    // enables gate the pin at once, so a write that clears them leaves no stale request
    pins.drq_o = pair_hot(sel) & {3{(s_reg.st == ACDC_RUN) & dma_on & fifo_want}}; // RULE_07
    pins.drq_oe = pair_hot(sel) & ({3{s_reg.dq[DQ_PULLDN]}} | pins.drq_o); // RULE_08
  end

  assign cfg.link = s_reg.c1[C1_LINK]; // RULE_15
  assign cfg.signed_fmt = s_reg.c1[C1_SIGNED]; // RULE_17
  assign cfg.stereo = s_reg.c1[C1_STEREO]; // RULE_18
  assign cfg.wide = s_reg.c1[C1_WIDE]; // RULE_18
  assign cfg.dac_mode = s_reg.c2[C2_DAC]; // RULE_20
  assign cfg.auto_init = s_reg.c2[C2_AUTO]; // RULE_20
  assign cfg.read_dir = s_reg.c2[C2_READ]; // RULE_21
  assign cfg.vol_left = s_reg.vol[7:4]; // RULE_13
  assign cfg.vol_right = s_reg.vol[3:0]; // RULE_13
  assign compat_irq_mode = s_reg.li[LI_COMPAT]; // RULE_01
  assign dac_data = s_reg.dac;
  assign dac_load = s_reg.dac_load;
  assign byte_taken = ack_seen & (s_reg.st == ACDC_RUN);
  assign rdata = s_reg.rdata;
  assign rvalid = s_reg.rvalid;
  assign irq = s_reg.irq;

endmodule : acdc_top

// File: sim/acdc_checker.sv
// acdc_checker: port-level checks of acdc_top
// assumes: shadow registers follow bus writes; one clock domain
`timescale 1ns/10ps
module acdc_checker import acdc_pkg::*; (
  // clock and reset
  input logic clk,
  input logic rst,
  // watched ports
  input acdc_pkg::acdc_req_s req,
  input acdc_pkg::acdc_cfg_s cfg,
  input logic [15:0] dac_data,
  input logic dac_load,
  input logic byte_taken,
  input acdc_pkg::acdc_pins_s pins,
  input logic compat_irq_mode,
  input logic irq
);
  logic [7:0] li_reg, dq_reg, c1_reg, c2_reg, vol_reg;
  logic [15:0] hold_reg;
  logic [2:0] sel_oh;
  ////////////////////////////////////////////////////////////////
  // shadows of the fields the checks need
  always_ff @(posedge clk) begin
    if (rst) begin
      li_reg <= 8'h00;
      dq_reg <= 8'h00;
      c1_reg <= 8'h10;
      c2_reg <= 8'h00;
      vol_reg <= 8'hFF;
      hold_reg <= 16'h0000;
    end else if (req.wr) begin
      case (req.addr)
        ADDR_LEGACY_IRQ: li_reg <= req.wdata;
        ADDR_DRQ_CTRL: dq_reg <= req.wdata;
        ADDR_IN_VOL: vol_reg <= req.wdata;
        ADDR_HOLD_LO: hold_reg[7:0] <= req.wdata;
        ADDR_HOLD_HI: hold_reg[15:8] <= req.wdata;
        ADDR_CTRL_ONE: c1_reg <= req.wdata;
        ADDR_CTRL_TWO: c2_reg <= req.wdata;
        default: ;
      endcase
    end
  end
  // pair code to pin one-hot
  assign sel_oh = (dq_reg[3:2] == PAIR_NONE) ? 3'h0 : 3'(3'h1 << (dq_reg[3:2] - 2'h1));
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // both enables low for two cycles, so a state lag cannot excuse a request
  sequence s_disabled;
    dq_reg[6:5] == 2'h0 && $past(dq_reg[6:5]) == 2'h0;
  endsequence
  sequence s_load_cmd;
    req.wr && req.addr == ADDR_CTRL_ONE && req.wdata[C1_LOAD];
  endsequence
  a_compat_irq_bit: assert property (
    req.wr && req.addr == ADDR_LEGACY_IRQ |=> compat_irq_mode == li_reg[LI_COMPAT])
    else $error("interrupt scheme bit wrong");
  a_mask_all_quiet: assert property ($past(li_reg[LI_MASK_ALL]) |-> !irq)
    else $error("interrupt while all masked");
  a_drq_idle_low: assert property (s_disabled |-> pins.drq_o == 3'h0)
    else $error("request active while disabled");
  a_drq_now_off: assert property (dq_reg[6:5] == 2'h0 |-> pins.drq_o == 3'h0)
    else $error("request active in the cycle its enables clear");
  a_drq_pulldown: assert property (
    s_disabled |-> pins.drq_oe == (dq_reg[DQ_PULLDN] ? sel_oh : 3'h0))
    else $error("idle request drive wrong");
  a_pair_only: assert property ((pins.drq_oe & ~sel_oh) == 3'h0)
    else $error("unselected pair driven");
  a_reset_drq_off: assert property ($fell(rst) |-> pins.drq_oe == 3'h0)
    else $error("request pin driven after reset");
  a_vol_reset: assert property ($fell(rst) |-> {cfg.vol_left, cfg.vol_right} == 8'hFF)
    else $error("volume reset value wrong");
  a_load_on_sample: assert property (s_load_cmd |-> ##[1:40] dac_load)
    else $error("dac load missing");
  a_load_value: assert property (dac_load |-> dac_data == hold_reg)
    else $error("dac value differs from holding register");
  a_cfg_mirror: assert property (
    {cfg.link, cfg.signed_fmt, cfg.stereo, cfg.wide} == {c1_reg[7], c1_reg[5], c1_reg[3:2]}
    && {cfg.dac_mode, cfg.auto_init, cfg.read_dir} == c2_reg[3:1]
    && {cfg.vol_left, cfg.vol_right} == vol_reg)
    else $error("format or direction output wrong");
  a_run_gate: assert property (
    !c2_reg[C2_RUN_N] && !$past(c2_reg[C2_RUN_N]) |-> !byte_taken && pins.drq_o == 3'h0)
    else $error("dma active while held in reset");
endmodule : acdc_checker

bind acdc_top acdc_checker acdc_checker_i (.clk(clk), .rst(rst), .req(req), .cfg(cfg),
  .dac_data(dac_data), .dac_load(dac_load), .byte_taken(byte_taken), .pins(pins),
  .compat_irq_mode(compat_irq_mode), .irq(irq));

// File: sim/acdc_dma_host_model.sv
// acdc_dma_host_model: system dma controller answering requests with acknowledges
// assumes: acknowledge lines idle high through board pull-ups
`timescale 1ns/10ps
module acdc_dma_host_model (
  // clock and pacing
  input logic clk,
  input logic slow,
  // request and acknowledge pins
  input acdc_pkg::acdc_pins_s pins,
  output logic [2:0] ack_n
);
  int gap = 0;
  // one-cycle acknowledge per request, then a gap so a halting device can drop its request
  always @(posedge clk) begin
    if (gap > 0) begin
      ack_n <= 3'h7;
      gap <= gap - 1;
    end else if ((pins.drq_o & pins.drq_oe) != 3'h0) begin
      ack_n <= ~(pins.drq_o & pins.drq_oe);
      gap <= slow ? 11 : 5;
    end else begin
      ack_n <= 3'h7;
    end
  end
endmodule : acdc_dma_host_model

// File: sim/acdc_top_tb.sv
// acdc_top_tb: register table, reset values, dac load and dma transfer cases
// assumes: acdc_top with the dma host model on its request pins
`timescale 1ns/10ps
module acdc_top_tb;
  import acdc_pkg::*;
  logic clk, rst, fifo_want, half_toggle, sample_clk, slow;
  acdc_req_s req;
  acdc_cfg_s cfg;
  acdc_pins_s pins;
  logic [7:0] rdata, got;
  logic [15:0] dac_data;
  logic [2:0] ack_n;
  logic rvalid, dac_load, block_io, byte_taken, compat_irq_mode, irq;
  int fail_count = 0;
  int check_count = 0;
  int bytes, irqs, n;
  // address, value written, value read back
  logic [23:0] rows [10] = '{24'hB1FFFC, 24'hB10C0C, 24'hB29D9C, 24'hB45A5A, 24'hB53434,
    24'hB61212, 24'hB7BCBC, 24'hB8FF0F, 24'hB9FF03, 24'hB35500};
  logic [15:0] rst_rows [7] = '{16'hB100, 16'hB200, 16'hB4FF, 16'hB500, 16'hB600,
    16'hB710, 16'hB800};
  // interrupt mask, interrupts expected over four bytes and one half-empty event
  logic [15:0] mrows [4] = '{16'h1000, 16'h4001, 16'h2002, 16'h0003};

  acdc_top acdc_top_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .fifo_want(fifo_want), .half_toggle(half_toggle), .sample_clk(sample_clk), .cfg(cfg),
    .dac_data(dac_data), .dac_load(dac_load), .block_io(block_io), .byte_taken(byte_taken),
    .dma_acknowledge_n(ack_n), .pins(pins), .compat_irq_mode(compat_irq_mode), .irq(irq));
  acdc_dma_host_model acdc_dma_host_model_i (.clk(clk), .slow(slow), .pins(pins),
    .ack_n(ack_n));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // sample clock unrelated in phase to clk
  initial begin
    sample_clk = 1'b0;
    forever #173 sample_clk = ~sample_clk;
  end
  // counters read the values settled before each edge
  always @(posedge clk) begin
    if (byte_taken === 1'b1) bytes++;
    if (irq === 1'b1) irqs++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : wr
  // read answer stands for one cycle after the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk({15'h0000, rvalid}, 16'h0001);
    got = rdata;
  endtask : rd
  task automatic conclude();
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic wait_cnt(ref int c, input int want);
    for (n = 0; n < 400 && c < want; n++) begin
      @(posedge clk);
      #1;
    end
    if (c < want) begin
      chk(16'(c), 16'(want));
      conclude();
    end
  endtask : wait_cnt
  // align to a byte so no earlier interrupt leaks into the count window
  task automatic phase(input logic [7:0] li);
    wr(ADDR_LEGACY_IRQ, li);
    bytes = 0;
    wait_cnt(bytes, 1);
    repeat (2) @(posedge clk);
    #1;
    irqs = 0;
    bytes = 0;
    @(posedge clk);
    half_toggle <= 1'b1;
    @(posedge clk);
    half_toggle <= 1'b0;
    wait_cnt(bytes, 4);
    repeat (2) @(posedge clk);
    #1;
  endtask : phase
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    req = '0;
    fifo_want = 1'b0;
    half_toggle = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(16'(got), 16'(rows[i][7:0]));
    end
    // mid-run reset returns the registers at B1h to B8h to their reset values; reload and transfer type are not read back
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    foreach (rst_rows[i]) begin
      rd(rst_rows[i][15:8]);
      chk(16'(got), 16'(rst_rows[i][7:0]));
    end
    chk({15'h0000, block_io}, 16'h0001);
    // dac load waits for the sample clock, then the load bit clears
    wr(ADDR_HOLD_LO, 8'hCD);
    wr(ADDR_HOLD_HI, 8'hAB);
    wr(ADDR_CTRL_ONE, 8'h51);
    for (n = 0; n < 60 && dac_load !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(dac_data, 16'hABCD);
    if (n == 60) begin
      fail_count++;
      conclude();
    end
    rd(ADDR_CTRL_ONE);
    chk(16'(got), 16'h0050);
    // normal mode: two bytes to overflow, then requests stop
    wr(ADDR_RELOAD_LO, 8'hFE);
    wr(ADDR_RELOAD_HI, 8'hFF);
    wr(ADDR_DRQ_CTRL, 8'h54);
    chk({15'h0000, block_io}, 16'h0000);
    @(posedge clk);
    fifo_want <= 1'b1;
    #1;
    bytes = 0;
    irqs = 0;
    wr(ADDR_CTRL_TWO, 8'h09);
    wait_cnt(irqs, 1);
    repeat (60) @(posedge clk);
    #1;
    chk(16'(bytes), 16'h0002);
    chk(16'(irqs), 16'h0001);
    chk(16'(pins.drq_o), 16'h0000);
    // auto mode keeps going with a slow controller, one interrupt per overflow
    wr(ADDR_CTRL_TWO, 8'h08);
    slow = 1'b1;
    bytes = 0;
    irqs = 0;
    wr(ADDR_CTRL_TWO, 8'h0D);
    wait_cnt(irqs, 2);
    chk(16'(bytes), 16'h0004);
    foreach (mrows[i]) begin
      phase(mrows[i][15:8]);
      chk(16'(irqs), 16'(mrows[i][7:0]));
    end
    // compatibility enable alone moves the transfer to pair b
    wr(ADDR_DRQ_CTRL, 8'hB8);
    chk({15'h0000, block_io}, 16'h0000);
    bytes = 0;
    wait_cnt(bytes, 2);
    chk(16'(pins.drq_oe), 16'h0002);
    chk(16'(pins.drq_o), 16'h0002);
    conclude();
  end
endmodule : acdc_top_tb
